// ==== hdl/adcsi_top.sv ====
// Serial port slave of the delta-sigma converter with ready signalling.
//
// Summary of operation
// [R1] Link uses clock idle low, phase one.
// [R2] Launch on rising edge, sample on falling.
// [R3] Clock low past 28 ms aborts frame.
// [R4] Master keeps clock gaps below 28 ms.
// [R5] Weak pullup while deselected by default.
// [R6] Pullup cleared: line floats when deselected.
// [R7] No ready pulse while deselected.
// [R8] Select fall starts active line drive.
// [R9] Unread new result: line driven low.
// [R10] No new result: high, repeat old.
// [R11] Mid-frame conversion waits for next frame.
// [R12] Reads at any time stay uncorrupted.
// [R13] Master polls each select for ready.
// [R14] Shared lines, one select per device.
// [R15] Mux offers four single-ended inputs.
// [R16] Mux offers three inputs against fourth.
// [R17] Pullup enable bit three, resets set.
// [R18] Config updates only with qualifier 01.
// [R19] Timeout restarts the bit counter.
`default_nettype none

module adcsi_top
#(
    parameter int TMO_CYCLES = adcsi_pkg::TMO_CYC
)
(
    // System clock and reset.
    input  wire logic              clk_sys,
    input  wire logic              rstn,
    // Serial link pins.
    input  wire logic              sclk_link,
    input  wire logic              cs_n_i,
    input  wire logic              din_i,
    output logic                   data_out_ready_line_o,
    output logic                   data_out_ready_line_oe,
    output logic                   data_out_ready_line_pu,
    // Conversion core side.
    input  wire logic              conv_valid_i,
    input  wire logic [15:0]       conv_data_i,
    output logic [15:0]            cfg_o,
    output adcsi_pkg::adcsi_sel_t  sel_o
);
    import adcsi_pkg::*;

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (TMO_CYCLES < 2 || TMO_CYCLES > (1 << TMO_W) - 1)
    begin : g_bad_tmo
        $error("TMO_CYCLES out of range for the timeout counter.");
    end

    localparam logic [TMO_W-1:0] TMO_LAST = TMO_W'(TMO_CYCLES - 1);
    localparam logic [TMO_W-1:0] TMO_SAT  = TMO_W'(TMO_CYCLES);

    // ------------------------------------------------------------
    // Mux decoding
    // ------------------------------------------------------------
    // Maps the three-bit mux field onto the input pair.
    function automatic adcsi_sel_t mux_decode(input logic [2:0] code);
        adcsi_sel_t s;
        s = '{AIN_A, AIN_B};
        unique case (code)
            3'h0: s = '{AIN_A, AIN_B};
            3'h1: s = '{AIN_A, AIN_D};   // R16
            3'h2: s = '{AIN_B, AIN_D};   // R16
            3'h3: s = '{AIN_C, AIN_D};   // R16
            3'h4: s = '{AIN_A, AIN_GND}; // R15
            3'h5: s = '{AIN_B, AIN_GND}; // R15
            3'h6: s = '{AIN_C, AIN_GND}; // R15
            3'h7: s = '{AIN_D, AIN_GND}; // R15
        endcase
        return s;
    endfunction

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic [1:0] rst_sync_r;  // Reset release synchroniser.
    logic       rst_n;       // Synchronised active-low reset.

    // The reset is taken asynchronously but released on a clock edge.
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            rst_sync_r <= 2'h0;
        else
            rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
    assign rst_n = rst_sync_r[1];

    // ------------------------------------------------------------
    // Link domain
    // ------------------------------------------------------------
    adcsi_sys_t  st_r;        // System domain state.
    adcsi_sys_t  st_nxt;      // Its next value.
    logic        frame_rst_n; // Ends a frame on deselect or abort.
    logic        started_r;   // A rising edge has launched a bit.
    logic [3:0]  rise_cnt_r;  // Bits launched so far.
    logic        bit_r;       // Bit on the line after a launch.
    logic [3:0]  fall_cnt_r;  // Bits sampled so far.
    logic [14:0] shin_r;      // Incoming bits of the frame.
    logic [15:0] word_in;     // Whole incoming word at the last bit.
    logic [15:0] cfg_lnk_r;   // Accepted word, held for the crossing.
    logic        cfg_tgl_r;   // Flips once per accepted word.

    // The link clock stops between frames, so the frame state is
    // cleared asynchronously by the select pin or by a timeout
    // abort. The abort lasts one system cycle while the serial clock
    // is low, so no edge of the next frame is lost.
    assign frame_rst_n = rst_n & ~cs_n_i & ~st_r.abort; // R19

    // Bits are launched on the rising edge, most significant first,
    // from the word frozen at select time.
    always_ff @(posedge sclk_link or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
        begin
            started_r  <= 1'b0;
            rise_cnt_r <= 4'h0;
            bit_r      <= 1'b1;
        end
        else
        begin
            started_r  <= 1'b1;                          // R1
            bit_r      <= st_r.shadow[LAST_BIT - rise_cnt_r]; // R2
            rise_cnt_r <= rise_cnt_r + 4'h1;
        end
    end

    // Incoming bits are sampled on the falling edge.
    always_ff @(negedge sclk_link or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
        begin
            fall_cnt_r <= 4'h0;
            shin_r     <= 15'h0;
        end
        else
        begin
            fall_cnt_r <= fall_cnt_r + 4'h1;     // R2
            shin_r     <= {shin_r[13:0], din_i}; // R2
        end
    end

    assign word_in = {shin_r, din_i};

    // The configuration word survives deselect, so it uses only the
    // global reset. Only a qualified word is taken.
    always_ff @(negedge sclk_link or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfg_lnk_r <= CFG_RST;
            cfg_tgl_r <= 1'b0;
        end
        else if (frame_rst_n && fall_cnt_r == LAST_BIT &&
                 word_in[QUAL_HI:QUAL_LO] == QUAL_WRITE) // R18
        begin
            cfg_lnk_r <= word_in;
            cfg_tgl_r <= ~cfg_tgl_r;
        end
    end

    // ------------------------------------------------------------
    // System domain
    // ------------------------------------------------------------
    logic cs_low;   // Select is asserted, after synchronising.
    logic cs_fall;  // Select has just been asserted.
    logic cfg_new;  // A new configuration word has crossed over.

    // Next-state logic: select tracking, result capture, timeout and
    // configuration crossing.
    always_comb
    begin
        st_nxt           = st_r;
        cs_low           = ~st_r.cs_sync[1];
        cs_fall          = st_r.cs_sync[2] & ~st_r.cs_sync[1];
        cfg_new          = st_r.tgl_sync[2] ^ st_r.tgl_sync[1];
        st_nxt.cs_sync   = {st_r.cs_sync[1:0], cs_n_i};
        st_nxt.sclk_sync = {st_r.sclk_sync[0], sclk_link};
        st_nxt.tgl_sync  = {st_r.tgl_sync[1:0], cfg_tgl_r};
        // Capture freezes the word for the whole frame, so a result
        // arriving mid-frame never tears the word being shifted.
        if (cs_fall)
        begin
            st_nxt.shadow  = st_r.result;   // R11 R12 R10
            st_nxt.rdy_lvl = ~st_r.newf;    // R9 R10
            st_nxt.newf    = 1'b0;
        end
        // A new result wins over the clear in the same cycle.
        if (conv_valid_i)
        begin
            st_nxt.result = conv_data_i;
            st_nxt.newf   = 1'b1;           // R11
        end
        // The line is driven only while selected; the weak pullup
        // applies only while deselected and enabled.
        // Only the selected device drives the shared line.
        st_nxt.oe = cs_low;                               // R8 R7 R14
        st_nxt.pu = ~cs_low & st_r.cfg[PU_BIT];          // R5 R6 R17
        // Count time with the serial clock low inside a frame.
        st_nxt.abort = 1'b0;
        if (!cs_low || st_r.sclk_sync[1])
            st_nxt.tmo_cnt = '0;
        else if (st_r.tmo_cnt != TMO_SAT)
            st_nxt.tmo_cnt = st_r.tmo_cnt + TMO_W'(1);
        if (cs_low && !st_r.sclk_sync[1] && st_r.tmo_cnt == TMO_LAST)
            st_nxt.abort = 1'b1;                          // R3
        // The link word is stable for many system cycles after its
        // toggle, so it is copied without further handshake.
        if (cfg_new)
        begin
            st_nxt.cfg = cfg_lnk_r;                       // R18
            st_nxt.sel = mux_decode(cfg_lnk_r[MUX_HI:MUX_LO]);
        end
    end

    // State register with its reset values.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r         <= '0;
            st_r.cs_sync <= 3'h7;
            st_r.rdy_lvl <= 1'b1;
            st_r.pu      <= 1'b1;
            st_r.cfg     <= CFG_RST;              // R17
            st_r.sel     <= '{AIN_A, AIN_B};
        end
        else
            st_r <= st_nxt;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Before the first launch the line shows the ready level; after
    // it the launched bits. Both sources are flip-flops.
    assign data_out_ready_line_o  = started_r ? bit_r : st_r.rdy_lvl;
    assign data_out_ready_line_oe = st_r.oe;
    assign data_out_ready_line_pu = st_r.pu;
    assign cfg_o                  = st_r.cfg;
    assign sel_o                  = st_r.sel;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_oe_follows_select: assert property ( // R8
        (st_r.cs_sync[1:0] == 2'h0) |=> data_out_ready_line_oe)
        else $error("Line not driven while selected.");

    a_pullup_while_idle: assert property ( // R5
        (st_r.cs_sync[1] && st_r.cfg[PU_BIT]) |=>
        (data_out_ready_line_pu && !data_out_ready_line_oe))
        else $error("Pullup missing while deselected.");

    a_float_no_pullup: assert property ( // R6
        (st_r.cs_sync[1] && !st_r.cfg[PU_BIT]) |=>
        (!data_out_ready_line_pu && !data_out_ready_line_oe))
        else $error("Line not floating with pullup off.");

    a_no_drive_idle: assert property ( // R7
        st_r.cs_sync[1] |=> !data_out_ready_line_oe)
        else $error("Line driven while deselected.");

    a_ready_low_new: assert property ( // R9
        (cs_fall && st_r.newf) |=> (!st_r.rdy_lvl && st_r.oe))
        else $error("Ready level not low with new result.");

    a_ready_high_old: assert property ( // R10
        (cs_fall && !st_r.newf) |=>
        (st_r.rdy_lvl && st_r.shadow == $past(st_r.shadow)))
        else $error("Old result not repeated.");

    a_shadow_frozen: assert property ( // R11
        (cs_low && !cs_fall) |=> $stable(st_r.shadow))
        else $error("Frame word changed mid-frame.");

    a_new_kept: assert property ( // R12
        (cs_fall && conv_valid_i) |=> st_r.newf)
        else $error("Result lost at select time.");

    a_timeout_abort: assert property ( // R3
        (cs_low && !st_r.sclk_sync[1] && st_r.tmo_cnt == TMO_LAST)
        |=> (st_r.abort ##1 !st_r.abort))
        else $error("Timeout abort not a single pulse.");

    // The serial clock is low during the abort, so no edge can refill
    // the counters before this sample.
    a_abort_clears: assert property ( // R19
        st_r.abort |-> (rise_cnt_r == 4'h0 && fall_cnt_r == 4'h0 &&
                        !started_r))
        else $error("Abort did not clear the frame.");

    a_cfg_update: assert property ( // R18
        cfg_new |=> (st_r.cfg == $past(cfg_lnk_r)))
        else $error("Config not copied after crossing.");

    a_mux_single: assert property ( // R15
        (st_r.cfg[MUX_HI:MUX_LO] == 3'h6) |->
        (st_r.sel.pos == AIN_C && st_r.sel.neg == AIN_GND))
        else $error("Single-ended selection wrong.");

    a_mux_common: assert property ( // R16
        (st_r.cfg[MUX_HI:MUX_LO] == 3'h2) |->
        (st_r.sel.pos == AIN_B && st_r.sel.neg == AIN_D))
        else $error("Common-point selection wrong.");

    c_new_read: cover property (cs_fall && st_r.newf);
    c_old_read: cover property (cs_fall && !st_r.newf);
    c_timeout:  cover property (st_r.abort);
    c_cfg_write: cover property (cfg_new);
    c_race_read: cover property (cs_fall && conv_valid_i);

endmodule // adcsi_top

`default_nettype wire

// ==== hdl/adcsi_pkg.sv ====
// Shared constants and types for the converter serial port block.
`default_nettype none

package adcsi_pkg;

    // ------------------------------------------------------------
    // Frame and configuration word layout
    // ------------------------------------------------------------
    localparam int          WORD_W     = 16;       // Bits per frame.
    localparam logic [3:0]  LAST_BIT   = 4'hf;     // Index of last bit.
    localparam logic [15:0] CFG_RST    = 16'h058b; // Config reset value.
    localparam int          PU_BIT     = 3;        // Pullup enable bit.
    localparam int          QUAL_LO    = 1;        // Qualifier low bit.
    localparam int          QUAL_HI    = 2;        // Qualifier high bit.
    localparam logic [1:0]  QUAL_WRITE = 2'h1;     // Qualifier for update.
    localparam int          MUX_LO     = 12;       // Mux field low bit.
    localparam int          MUX_HI     = 14;       // Mux field high bit.

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam longint CLK_HZ    = 20000000;       // System clock rate.
    localparam longint TMO_MS    = 28;             // Clock-low timeout.
    localparam int     TMO_CYC   = int'((TMO_MS * CLK_HZ) / 1000);
    localparam int     TMO_W     = 20;             // Timeout counter width.

    // ------------------------------------------------------------
    // Input selection
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        AIN_A   = 5'h01,
        AIN_B   = 5'h02,
        AIN_C   = 5'h04,
        AIN_D   = 5'h08,
        AIN_GND = 5'h10
    } adcsi_ain_t;

    // Positive and negative converter input of one setting.
    typedef struct packed {
        adcsi_ain_t pos;
        adcsi_ain_t neg;
    } adcsi_sel_t;

    // All state of the system clock domain.
    typedef struct packed {
        logic [1:0]       rst_unused;
        logic [2:0]       cs_sync;
        logic [1:0]       sclk_sync;
        logic [2:0]       tgl_sync;
        logic [TMO_W-1:0] tmo_cnt;
        logic             abort;
        logic             newf;
        logic [15:0]      result;
        logic [15:0]      shadow;
        logic             rdy_lvl;
        logic             oe;
        logic             pu;
        logic [15:0]      cfg;
        adcsi_sel_t       sel;
    } adcsi_sys_t;

endpackage : adcsi_pkg

`default_nettype wire

// ==== verif/adcsi_mst_model.sv ====
// Mode 1 serial master model that drives the converter serial port.
`default_nettype none

module adcsi_mst_model
(
    // Link pins driven by the master.
    output var logic sclk_link,
    output var logic cs_n_i,
    output var logic din_i,
    // Resolved data-out and ready line.
    input  wire logic line
);
    timeunit 1ns;
    timeprecision 100ps;

    // Idle link: the clock rests low and stands still outside frames.
    initial
    begin
        sclk_link = 1'b0;
        cs_n_i    = 1'b1;
        din_i     = 1'b0;
    end

    // Drop this device's own select and sample its ready level.
    task automatic sel(output logic rdy);
    begin
        cs_n_i = 1'b0;
        #300;
        rdy = line;
    end
    endtask

    // Shift n bits MSB first, launch on rise, sample on fall.
    task automatic shift(input int n, input logic [15:0] tx,
                         output logic [15:0] rx);
        int i;
    begin
        rx = 16'h0000;
        for (i = 15; i > 15 - n; i--)
        begin
            sclk_link = 1'b1;
            din_i     = tx[i];
            #62.5;
            sclk_link = 1'b0;
            rx[i]     = line;
            #62.5;
        end
        // A released data line must not keep showing the last bit.
        din_i = ~din_i;
    end
    endtask

    // Raise the select and keep it high long enough between frames.
    task automatic desel();
    begin
        cs_n_i = 1'b1;
        #300;
    end
    endtask
endmodule // adcsi_mst_model

`default_nettype wire

// ==== verif/adc_spi_ready_interface_bench.sv ====
// Self-checking testbench of the converter serial port block.
`default_nettype none

module adc_spi_ready_interface_bench;
    import adcsi_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clk_sys, rstn, sclk_link, cs_n_i, din_i;
    logic        line_o, line_oe, line_pu, conv_valid_i;
    logic [15:0] conv_data_i, cfg_o, cfg_exp, rx;
    logic        rdy;
    adcsi_sel_t  sel_o;
    wire         line;
    int          miscompares, n_tests;
    // Expected mux selections, indexed by the three-bit mux field.
    adcsi_ain_t  pos_t [8] = '{AIN_A, AIN_A, AIN_B, AIN_C,
                               AIN_A, AIN_B, AIN_C, AIN_D};
    adcsi_ain_t  neg_t [8] = '{AIN_B, AIN_D, AIN_D, AIN_D,
                               AIN_GND, AIN_GND, AIN_GND, AIN_GND};

    // Wire level: device drive, else weak pullup, else floating.
    assign line = line_oe ? line_o : (line_pu ? 1'b1 : 1'bz);

    // Short timeout count keeps the clock-low abort quick to reach.
    adcsi_top #(.TMO_CYCLES(20)) dut_u (
        .clk_sys(clk_sys), .rstn(rstn), .sclk_link(sclk_link),
        .cs_n_i(cs_n_i), .din_i(din_i), .data_out_ready_line_o(line_o),
        .data_out_ready_line_oe(line_oe),
        .data_out_ready_line_pu(line_pu), .conv_valid_i(conv_valid_i),
        .conv_data_i(conv_data_i), .cfg_o(cfg_o), .sel_o(sel_o));

    adcsi_mst_model mst_u (.sclk_link(sclk_link), .cs_n_i(cs_n_i),
                           .din_i(din_i), .line(line));

    // ------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------
    task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    begin
        n_tests++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    end
    endtask

    // One-cycle result pulse from the conversion core.
    task automatic pulse(logic [15:0] d);
    begin
        @(negedge clk_sys);
        conv_valid_i = 1'b1;
        conv_data_i  = d;
        @(negedge clk_sys);
        conv_valid_i = 1'b0;
        conv_data_i  = ~d;
    end
    endtask

    // Whole frame; the line must be actively driven before shifting.
    task automatic frame(logic [15:0] tx);
    begin
        mst_u.sel(rdy);
        chk("drive", {15'h0, line_oe}, 16'h1);
        mst_u.shift(16, tx, rx);
        mst_u.desel();
    end
    endtask

    task automatic finish_test();
    begin
        $display("compares %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    end
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
    begin
        chk("cfg", cfg_o, CFG_RST);
        chk("pu", {15'h0, line_pu}, 16'h1);
        chk("line", {15'h0, line}, 16'h1);
        chk("sel", {6'h0, sel_o}, {6'h0, AIN_A, AIN_B});
        $display("test reset done");
    end
    endtask

    // Every mux code written with the update qualifier.
    task automatic t_mux();
    begin
        for (int m = 0; m < 8; m++)
        begin
            cfg_exp = {1'b0, 3'(m), 12'h58b};
            frame(cfg_exp);
            chk("cfg", cfg_o, cfg_exp);
            chk("sel", {6'h0, sel_o}, {6'h0, pos_t[m], neg_t[m]});
        end
        $display("test mux done");
    end
    endtask

    // Every other qualifier value must leave the word alone.
    task automatic t_qual();
    begin
        for (int q = 0; q < 4; q++)
        begin
            if (q == 1)
                continue;
            frame(16'h3580 | 16'(q << 1));
            chk("cfg", cfg_o, cfg_exp);
        end
        $display("test qualifier done");
    end
    endtask

    task automatic t_ready();
    begin
        frame(16'h0000);
        chk("rdy", {15'h0, rdy}, 16'h1);
        pulse(16'ha5c3);
        frame(16'h0000);
        chk("rdy", {15'h0, rdy}, 16'h0);
        chk("word", rx, 16'ha5c3);
        frame(16'h0000);
        chk("rdy", {15'h0, rdy}, 16'h1);
        chk("word", rx, 16'ha5c3);
        $display("test ready done");
    end
    endtask

    // A result landing mid-frame waits for the next select.
    task automatic t_mid();
    begin
        pulse(16'h1234);
        fork
            frame(16'h0000);
            begin
                #1200;
                pulse(16'hbeef);
            end
        join
        chk("rdy", {15'h0, rdy}, 16'h0);
        chk("word", rx, 16'h1234);
        frame(16'h0000);
        chk("rdy", {15'h0, rdy}, 16'h0);
        chk("word", rx, 16'hbeef);
        // A result landing in the very capture cycle is kept for the
        // next frame while this frame repeats the old word.
        @(negedge clk_sys);
        fork
            frame(16'h0000);
            begin
                #75;
                pulse(16'h5a5a);
            end
        join
        chk("rdy", {15'h0, rdy}, 16'h1);
        chk("word", rx, 16'hbeef);
        frame(16'h0000);
        chk("rdy", {15'h0, rdy}, 16'h0);
        chk("word", rx, 16'h5a5a);
        $display("test midframe done");
    end
    endtask

    // Pullup cleared: floating line, no ready pulse while deselected.
    task automatic t_float();
    begin
        cfg_exp = cfg_exp & 16'hfff7;
        frame(cfg_exp);
        chk("line", {15'h0, line}, {15'h0, 1'bz});
        pulse(16'h0f0f);
        repeat (8)
        begin
            @(negedge clk_sys);
            chk("oe", {15'h0, line_oe}, 16'h0);
        end
        cfg_exp = cfg_exp | 16'h0008;
        frame(cfg_exp);
        chk("rdy", {15'h0, rdy}, 16'h0);
        chk("word", rx, 16'h0f0f);
        chk("line", {15'h0, line}, 16'h1);
        $display("test float done");
    end
    endtask

    // Clock held low past the limit restarts the bit count.
    task automatic t_tmo();
    begin
        cfg_exp = 16'h258b;
        mst_u.sel(rdy);
        mst_u.shift(5, 16'hffff, rx);
        #2000;
        mst_u.shift(16, cfg_exp, rx);
        mst_u.desel();
        chk("cfg", cfg_o, cfg_exp);
        $display("test timeout done");
    end
    endtask

    // ------------------------------------------------------------
    // Clock, reset, sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    initial
    begin
        rstn = 1'b0;
        conv_valid_i = 1'b0;
        conv_data_i = 16'h0000;
        cfg_exp = CFG_RST;
        miscompares = 0;
        n_tests = 0;
        repeat (3) @(negedge clk_sys);
        rstn = 1'b1;
        repeat (5) @(negedge clk_sys);
        t_reset();
        t_mux();
        t_qual();
        t_ready();
        t_mid();
        t_float();
        t_tmo();
        finish_test();
    end

    // About twenty frames of a few microseconds each; allow far more.
    initial
    begin
        #500000;
        miscompares++;
        finish_test();
    end
endmodule // adc_spi_ready_interface_bench

`default_nettype wire
